// ===== hw/ccm_pkg.sv
package ccm_pkg;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          CNT_W_DEF   = 32;
    localparam logic [7:0]  CTRL_OFS    = 8'h00;
    localparam logic [7:0]  STAT_OFS    = 8'h04;
    localparam logic [7:0]  COUNT_OFS   = 8'h08;
    localparam logic [7:0]  SAVE_OFS    = 8'h0c;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_GFALL_BIT = 3;
    localparam int          CTRL_SFALL_BIT = 4;
    localparam int          CTRL_DIR_LSB   = 5;
    localparam int          CTRL_ARM_BIT   = 8;
    localparam int          CTRL_DISARM_BIT = 9;
    localparam int          STAT_ARMED_BIT = 0;
    localparam int          STAT_DONE_BIT  = 1;
    localparam int          STAT_OVR_BIT   = 2;
    localparam int          STAT_GATE_BIT  = 3;
    localparam int          STAT_SAVED_BIT = 4;
    localparam logic [31:0] UNMAPPED_RD    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // timing: input synchroniser depth, bus answer latency
    // ------------------------------------------------------------------
    localparam int          SYNC_STAGES = 2;
    localparam int          ACK_CYCLES  = 1;

    typedef enum logic [2:0] {
        MODE_EDGE_CUM    = 3'h0,
        MODE_EDGE_NONCUM = 3'h1,
        MODE_PW_SINGLE   = 3'h2,
        MODE_PW_BUF      = 3'h3,
        MODE_PER_SINGLE  = 3'h4,
        MODE_PER_BUF     = 3'h5,
        MODE_SEMI_SINGLE = 3'h6,
        MODE_SEMI_BUF    = 3'h7
    } ccm_mode_t;

    typedef enum logic [1:0] {
        DIR_UP   = 2'h0,
        DIR_DOWN = 2'h1,
        DIR_EXT  = 2'h2,
        DIR_RSVD = 2'h3
    } ccm_dir_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_RUN  = 2'h2,
        ST_DONE = 2'h3
    } ccm_state_t;

endpackage : ccm_pkg

// ===== hw/ccm_sync.sv
`timescale 1ns/1ps

module ccm_sync #(
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [N-1:0] async_i,
    output logic      [N-1:0] lvl_o,
    output logic      [N-1:0] rise_o,
    output logic      [N-1:0] fall_o
);
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] last_ff;

    // ------------------------------------------------------------------
    // two flops, then a third only for edge detection
    // ------------------------------------------------------------------
    // meta_ff feeds sync_ff and nothing else
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign lvl_o  = sync_ff;
    assign rise_o = sync_ff & ~last_ff;
    assign fall_o = ~sync_ff & last_ff;

endmodule : ccm_sync

// ===== hw/ccm_hold.sv
`timescale 1ns/1ps

module ccm_hold #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         push_i,
    input  wire logic [W-1:0] data_i,
    output logic              ovr_o,
    output logic              valid_o,
    output logic      [W-1:0] data_o,
    input  wire logic         ready_i
);
    logic         valid_ff;
    logic [W-1:0] data_ff;
    logic         room;

    // a full slot that is not draining refuses the new value
    assign room  = ~valid_ff | ready_i;
    assign ovr_o = push_i & ~room;

    // ------------------------------------------------------------------
    // single entry handed to the dma engine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_ff <= 1'b0;
        end else if (push_i && room) begin
            valid_ff <= 1'b1;
        end else if (ready_i) begin
            valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            data_ff <= '0;
        end else if (push_i && room) begin
            data_ff <= data_i;
        end
    end

    assign valid_o = valid_ff;
    assign data_o  = data_ff;

endmodule : ccm_hold

// ===== hw/ccm_counter.sv
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps

module ccm_counter
    import ccm_pkg::*;
#(
    parameter int CNT_W = ccm_pkg::CNT_W_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [ccm_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [ccm_pkg::DATA_W-1:0] wb_dat_i,
    output logic      [ccm_pkg::DATA_W-1:0] wb_dat_o,
    output logic                            wb_ack_o,
    input  wire logic                       gate_i,
    input  wire logic                       source_i,
    input  wire logic                       dir_i,
    output logic                            cap_valid_o,
    output logic      [CNT_W-1:0]           cap_data_o,
    input  wire logic                       cap_ready_i
);
    import ccm_pkg::*;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic mode_is_pw(input ccm_mode_t m);
        return m == MODE_PW_SINGLE || m == MODE_PW_BUF ||
               m == MODE_SEMI_SINGLE;
    endfunction : mode_is_pw

    function automatic logic mode_is_single(input ccm_mode_t m);
        return m == MODE_PW_SINGLE || m == MODE_PER_SINGLE ||
               m == MODE_SEMI_SINGLE;
    endfunction : mode_is_single

    function automatic logic mode_is_edge(input ccm_mode_t m);
        return m == MODE_EDGE_CUM || m == MODE_EDGE_NONCUM;
    endfunction : mode_is_edge

    // +1 or -1 in two's complement; wrap is free
    function automatic logic [CNT_W-1:0] step_of(input ccm_dir_t d,
                                                 input logic up_lvl);
        logic up;
        up = (d == DIR_UP) || (d == DIR_EXT && up_lvl);
        return up ? CNT_W'(1) : '1;
    endfunction : step_of

    logic                 ack_ff;
    logic [DATA_W-1:0]    dat_ff;
    ccm_mode_t            mode_ff;
    logic                 gfall_ff;
    logic                 sfall_ff;
    ccm_dir_t             dir_ff;
    logic                 arm_ff;
    logic                 disarm_ff;
    ccm_state_t           state_ff;
    ccm_state_t           nxt_state;
    logic [CNT_W-1:0]     count_ff;
    logic [CNT_W-1:0]     nxt_count;
    logic [CNT_W-1:0]     save_ff;
    logic                 saved_ff;
    logic                 ovr_ff;
    logic                 req;
    logic                 wr_ctrl;
    logic                 wr_stat;
    logic [2:0]           s_lvl;
    logic [2:0]           s_rise;
    logic [2:0]           s_fall;
    logic                 g_lead;
    logic                 g_trail;
    logic                 g_act;
    logic                 src_edge;
    logic                 cnt_en;
    logic [CNT_W-1:0]     count_plus;
    logic [CNT_W-1:0]     cap_val;
    logic                 cap_evt;
    logic                 capture;
    logic                 push;
    logic                 ovr_p;

    // ------------------------------------------------------------------
    // input synchronisers: 0 gate, 1 source, 2 direction
    // ------------------------------------------------------------------
    ccm_sync #(
        .N       (3)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .async_i ({dir_i, source_i, gate_i}),
        .lvl_o   (s_lvl),
        .rise_o  (s_rise),
        .fall_o  (s_fall)
    );

    // gate polarity picks sample edge, pulse level and period edge
    assign g_lead   = gfall_ff ? s_fall[0] : s_rise[0];
    assign g_trail  = gfall_ff ? s_rise[0] : s_fall[0];
    assign g_act    = s_lvl[0] ^ gfall_ff;
    assign src_edge = sfall_ff ? s_fall[1] : s_rise[1];

    // ------------------------------------------------------------------
    // wishbone slave, answer one cycle after the request
    // ------------------------------------------------------------------
    assign req     = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_ctrl = req & wb_we_i & (wb_adr_i == CTRL_OFS);
    assign wr_stat = req & wb_we_i & (wb_adr_i == STAT_OFS) & wb_sel_i[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req;
        end
    end

    // unmapped addresses still answer, with zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dat_ff <= UNMAPPED_RD;
        end else if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                CTRL_OFS:  dat_ff <= DATA_W'({dir_ff, sfall_ff, gfall_ff,
                                              mode_ff});
                STAT_OFS:  dat_ff <= DATA_W'({saved_ff, s_lvl[0], ovr_ff,
                                              state_ff == ST_DONE,
                                              state_ff != ST_IDLE});
                COUNT_OFS: dat_ff <= DATA_W'(count_ff);
                SAVE_OFS:  dat_ff <= DATA_W'(save_ff);
                default:   dat_ff <= UNMAPPED_RD;
            endcase
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // ------------------------------------------------------------------
    // configuration, low byte lane
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff  <= MODE_EDGE_CUM;
            gfall_ff <= 1'b0;
            sfall_ff <= 1'b0;
            dir_ff   <= DIR_UP;
        end else if (wr_ctrl && wb_sel_i[0]) begin
            mode_ff  <= ccm_mode_t'(wb_dat_i[CTRL_MODE_LSB +: 3]);
            gfall_ff <= wb_dat_i[CTRL_GFALL_BIT];
            sfall_ff <= wb_dat_i[CTRL_SFALL_BIT];
            dir_ff   <= ccm_dir_t'(wb_dat_i[CTRL_DIR_LSB +: 2]);
        end
    end

    // arm acts a cycle late so it sees a mode written alongside it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            arm_ff    <= 1'b0;
            disarm_ff <= 1'b0;
        end else begin
            arm_ff    <= wr_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_ARM_BIT];
            disarm_ff <= wr_ctrl & wb_sel_i[1] & wb_dat_i[CTRL_DISARM_BIT];
        end
    end

    // ------------------------------------------------------------------
    // counting and capture decisions
    // ------------------------------------------------------------------
    assign count_plus = count_ff + step_of(dir_ff, s_lvl[2]);
    // pulse-width style modes count only inside the active level
    assign cnt_en  = src_edge & (~mode_is_pw(mode_ff) | g_act);
    assign cap_val = cnt_en ? count_plus : count_ff;

    always_comb begin
        unique case (mode_ff)
            MODE_EDGE_CUM,
            MODE_EDGE_NONCUM: cap_evt = g_lead;
            MODE_PW_SINGLE,
            MODE_PW_BUF,
            MODE_SEMI_SINGLE: cap_evt = g_trail;
            MODE_PER_SINGLE,
            MODE_PER_BUF:     cap_evt = g_lead;
            MODE_SEMI_BUF:    cap_evt = s_rise[0] | s_fall[0];
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_count = count_ff;
        capture   = 1'b0;
        if (disarm_ff) begin
            nxt_state = ST_IDLE;
        end else if (arm_ff) begin
            nxt_count = '0;
            // measurements needing a clean start wait for a gate edge
            if (mode_is_pw(mode_ff) || mode_ff == MODE_PER_SINGLE) begin
                nxt_state = ST_WAIT;
            end else begin
                nxt_state = ST_RUN;
            end
        end else begin
            unique case (state_ff)
                ST_IDLE,
                ST_DONE: nxt_state = state_ff;
                ST_WAIT: if (g_lead) begin
                    nxt_state = ST_RUN;
                    nxt_count = '0;
                end
                ST_RUN: begin
                    if (cnt_en) begin
                        nxt_count = count_plus;
                    end
                    if (cap_evt) begin
                        capture = 1'b1;
                        // pulse modes keep the width readable; in MODE_PW_BUF the next
                        // leading edge restarts it from zero, the single ones stop
                        if (mode_ff != MODE_EDGE_CUM &&
                            !mode_is_pw(mode_ff)) begin
                            nxt_count = '0;
                        end
                        if (mode_is_single(mode_ff)) begin
                            nxt_state = ST_DONE;
                        end else if (mode_ff == MODE_PW_BUF) begin
                            nxt_state = ST_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // full width register, wraps with no overflow flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ------------------------------------------------------------------
    // save register and dma hand-over
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            save_ff  <= '0;
            saved_ff <= 1'b0;
        end else if (arm_ff) begin
            saved_ff <= 1'b0;
        end else if (capture) begin
            save_ff  <= cap_val;
            saved_ff <= 1'b1;
        end
    end

    assign push = capture & ~mode_is_single(mode_ff);

    // one slot only: the dma engine must keep pace or values drop
    ccm_hold #(
        .W       (CNT_W)
    ) u_hold (
        .clk     (clk),
        .reset_n (reset_n),
        .push_i  (push),
        .data_i  (cap_val),
        .ovr_o   (ovr_p),
        .valid_o (cap_valid_o),
        .data_o  (cap_data_o),
        .ready_i (cap_ready_i)
    );

    // sticky drop flag, write one to clear; a new drop beats the clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ovr_ff <= 1'b0;
        end else if (ovr_p) begin
            ovr_ff <= 1'b1;
        end else if (wr_stat && wb_dat_i[STAT_OVR_BIT]) begin
            ovr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence arm_s;
        arm_ff && !disarm_ff;
    endsequence

    sequence run_cap_s;
        state_ff == ST_RUN && !arm_ff && !disarm_ff && cap_evt;
    endsequence

    bus_ack_a: assert property (
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus request not answered in one cycle");
    arm_edge_a: assert property (
        arm_s and mode_is_edge(mode_ff) |=>
            state_ff == ST_RUN && count_ff == '0)
        else $error("edge count did not start at arm");
    pw_wait_a: assert property (
        arm_s and (mode_is_pw(mode_ff) && g_act) |=>
            state_ff == ST_WAIT)
        else $error("partial pulse not skipped");
    cum_keep_a: assert property (
        run_cap_s and mode_ff == MODE_EDGE_CUM |=>
            count_ff == $past(cap_val) && save_ff == count_ff)
        else $error("cumulative capture disturbed counter");
    noncum_zero_a: assert property (
        run_cap_s and mode_ff == MODE_EDGE_NONCUM |=>
            count_ff == '0 && save_ff == $past(cap_val))
        else $error("interval count not restarted");
    single_stop_a: assert property (
        state_ff == ST_DONE && !arm_ff && !disarm_ff |=>
            $stable(count_ff) && $stable(save_ff))
        else $error("finished measurement still moving");
    pw_gate_a: assert property (
        state_ff == ST_RUN && mode_is_pw(mode_ff) && !g_act &&
        !arm_ff && !disarm_ff |=> $stable(count_ff))
        else $error("counted outside active gate level");
    per_done_a: assert property (
        run_cap_s and mode_ff == MODE_PER_SINGLE |=>
            state_ff == ST_DONE && saved_ff)
        else $error("single period not finished on edge");
    dma_push_a: assert property (
        push |=> cap_valid_o)
        else $error("buffered capture not offered to dma");
    wrap_a: assert property (
        state_ff == ST_RUN && mode_ff == MODE_EDGE_CUM && cnt_en &&
        dir_ff == DIR_DOWN && count_ff == '0 && !arm_ff && !disarm_ff
        |=> count_ff == '1)
        else $error("counter did not wrap below zero");

endmodule : ccm_counter

// ===== tb/ccm_src_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// far side: signal sources on gate, source and direction
// ------------------------------------------------------------------
module ccm_src_model (
    input  wire logic clk,
    output logic      gate,
    output logic      source,
    output logic      dir
);
    // all lines idle low until a scenario moves them
    initial begin
        gate = 1'b0;
        source = 1'b0;
        dir = 1'b0;
    end

    // four cycles per level so the two-flop synchroniser never misses one
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk) source <= 1'b1;
            repeat (4) @(posedge clk);
            source <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulses

    // fast reference timebase as source: one rising edge every two cycles
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) source <= 1'b1;
            @(posedge clk) source <= 1'b0;
        end
    endtask : tick

    // gate level, then six cycles for the edge to pass the synchroniser
    task automatic level(input logic v);
        @(posedge clk) gate <= v;
        repeat (6) @(posedge clk);
    endtask : level

    // direction level, held until the next scenario
    task automatic steer(input logic v);
        @(posedge clk) dir <= v;
    endtask : steer
endmodule : ccm_src_model

// ===== tb/test_counter_input_measurement.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// bench for the counter input block
// ------------------------------------------------------------------
module test_counter_input_measurement;
    import ccm_pkg::*;

    logic        clk, reset_n, req, we, ack, rdy, vld, di, gf, stall;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, cdat, rd;
    logic        gate, src, dir;
    logic [31:0] got_q[$];
    int          err_count, num_checks, a, b, c;

    ccm_counter u_ccm_counter (.clk(clk), .reset_n(reset_n),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .gate_i(gate), .source_i(src), .dir_i(dir), .cap_valid_o(vld),
        .cap_data_o(cdat), .cap_ready_i(rdy));
    ccm_src_model u_src (.clk(clk), .gate(gate), .source(src), .dir(dir));

    // free-running clock, 5 ns period
    always #2.5 clk = ~clk;

    // dma side: random stalls, taken words queued for comparison
    always @(posedge clk) begin
        rdy <= !stall && ($urandom % 4) != 0;
        if (vld && rdy)
            got_q.push_back(cdat);
    end

    task automatic results();
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic single cycle, released only at the edge that sees ack
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        int i;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        sel <= w ? {2'($urandom), 2'b11} : 4'($urandom);
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 50);
        if (ack !== 1'b1) begin
            err_count++;
            results();
        end else begin
            rd = rdat;
            req <= 1'b0;
            we <= 1'b0;
        end
    endtask : wb

    // disarm, park gate, then arm with fresh random pulse counts
    task automatic arm(input logic [2:0] m, input logic g,
                       input logic [1:0] d, input logic g0);
        chk(32'(got_q.size()), 32'h0);
        wb(1'b1, CTRL_OFS, 32'h0000_0200);
        u_src.level(g0);
        got_q.delete();
        a = 1 + $urandom % 5;
        b = 1 + $urandom % 5;
        c = 1 + $urandom % 5;
        // bit 8 arms; source edge select drawn at random
        wb(1'b1, CTRL_OFS, {23'h0, 1'b1, 1'b0, d, 1'($urandom % 2), g, m});
    endtask : arm

    // next dma entry, bounded wait
    task automatic cap(input logic [31:0] exp);
        int i;
        i = 0;
        while (got_q.size() == 0 && i < 40) begin
            @(posedge clk);
            i++;
        end
        if (got_q.size() == 0) begin
            err_count++;
            results();
        end else
            chk(got_q.pop_front(), exp);
    endtask : cap

    // expected count for a direction code; code 3 counts down
    function automatic logic [31:0] ev(input logic [1:0] d, input logic x,
                                       input int n);
        return (d == DIR_UP || (d == DIR_EXT && x)) ? 32'(n) : -32'(n);
    endfunction : ev

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        req = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        sel = 4'h0;
        rdy = 1'b1;
        stall = 1'b0;
        err_count = 0;
        num_checks = 0;
        void'($urandom(7));
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, UNMAPPED_RD);
        // every direction code, cumulative, down wraps below zero
        for (int d = 0; d < 4; d++) begin
            di = 1'($urandom % 2);
            u_src.steer(di);
            arm(MODE_EDGE_CUM, 1'b0, 2'(d), 1'b0);
            u_src.pulses(a);
            u_src.level(1'b1);
            cap(ev(2'(d), di, a));
            u_src.pulses(b);
            u_src.level(1'b0);
            u_src.level(1'b1);
            cap(ev(2'(d), di, a + b));
        end
        // non-cumulative, sampled on the falling gate edge
        arm(MODE_EDGE_NONCUM, 1'b1, DIR_UP, 1'b0);
        u_src.pulses(a);
        u_src.level(1'b1);
        u_src.pulses(b);
        u_src.level(1'b0);
        cap(32'(a + b));
        u_src.pulses(c);
        u_src.level(1'b1);
        u_src.level(1'b0);
        cap(32'(c));
        // single pulse and semi-period, armed mid-pulse, both polarities
        for (int k = 0; k < 4; k++) begin
            gf = k[0];
            arm(k < 2 ? MODE_PW_SINGLE : MODE_SEMI_SINGLE, gf, DIR_UP, !gf);
            u_src.pulses(a);
            u_src.level(gf);
            u_src.pulses(b);
            u_src.level(!gf);
            u_src.pulses(c);
            u_src.level(gf);
            u_src.pulses(a);
            u_src.level(!gf);
            u_src.level(gf);
            wb(1'b0, SAVE_OFS, 32'h0);
            chk(rd, 32'(c));
            wb(1'b0, STAT_OFS, 32'h0);
            chk(32'(rd[STAT_DONE_BIT]), 32'h1);
        end
        // buffered pulse width, edges while gate low are not counted
        arm(MODE_PW_BUF, 1'b0, DIR_UP, 1'b0);
        u_src.pulses(a);
        u_src.level(1'b1);
        u_src.pulses(b);
        u_src.level(1'b0);
        cap(32'(b));
        u_src.pulses(c);
        u_src.level(1'b1);
        u_src.pulses(a);
        u_src.level(1'b0);
        cap(32'(a));
        // period single and buffered, rising then falling edge
        for (int k = 0; k < 2; k++) begin
            gf = k[0];
            arm(MODE_PER_SINGLE, gf, DIR_UP, gf);
            u_src.pulses(c);
            u_src.level(!gf);
            u_src.pulses(a);
            u_src.level(gf);
            u_src.pulses(b);
            u_src.level(!gf);
            u_src.pulses(c);
            u_src.level(gf);
            u_src.level(!gf);
            wb(1'b0, SAVE_OFS, 32'h0);
            chk(rd, 32'(a + b));
            arm(MODE_PER_BUF, gf, DIR_UP, gf);
            u_src.pulses(a);
            u_src.level(!gf);
            cap(32'(a));
            u_src.pulses(b);
            u_src.level(gf);
            u_src.pulses(c);
            u_src.level(!gf);
            cap(32'(b + c));
        end
        // buffered semi-period, every gate edge captures
        arm(MODE_SEMI_BUF, 1'b0, DIR_UP, 1'b0);
        u_src.pulses(a);
        u_src.level(1'b1);
        cap(32'(a));
        u_src.pulses(b);
        u_src.level(1'b0);
        cap(32'(b));
        u_src.tick(c);
        u_src.level(1'b1);
        cap(32'(c));
        // dma stalled: second capture is dropped and flagged
        stall <= 1'b1;
        u_src.pulses(a);
        u_src.level(1'b0);
        u_src.pulses(c);
        u_src.level(1'b1);
        wb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[STAT_OVR_BIT]), 32'h1);
        wb(1'b1, STAT_OFS, 32'h4);
        wb(1'b0, STAT_OFS, 32'h0);
        chk(32'(rd[STAT_OVR_BIT]), 32'h0);
        stall <= 1'b0;
        cap(32'(a));
        repeat (20) @(posedge clk);
        chk(32'(got_q.size()), 32'h0);
        results();
    end
endmodule : test_counter_input_measurement
